// ---- pts_consts.svh ----
// Register offsets, field positions, reset values and scaler codes of the period timer.
// Assumes inclusion by bare name from files that use them.
`ifndef PTS_CONSTS_SVH
`define PTS_CONSTS_SVH

`define PTS_ADDR_W 8
`define PTS_OFF_COUNT 8'h11
`define PTS_OFF_CONTROL 8'h12
`define PTS_OFF_PERIOD 8'h13
`define PTS_OFF_FLAGS 8'h0C
`define PTS_OFF_ENABLE 8'h8C

`define PTS_RST_COUNT 8'h00
`define PTS_RST_PERIOD 8'hFF
`define PTS_RST_CONTROL 7'h00
`define PTS_RST_ZERO8 8'h00

`define PTS_BIT_MATCH 1
`define PTS_BIT_ON 2
`define PTS_CKPS_LO 0
`define PTS_CKPS_HI 1
`define PTS_POST_LO 3
`define PTS_POST_HI 6
`define PTS_CONTROL_W 7

`define PTS_PRE_DIV1 2'b00
`define PTS_PRE_DIV4 2'b01
`define PTS_PRE_LAST4 4'h3
`define PTS_PRE_LAST16 4'hF
`define PTS_QUARTER_LAST 2'b11
`define PTS_ONE4 4'h1
`define PTS_ONE2 2'b01
`define PTS_ONE8 8'h01

`endif

// ---- pts_scaler.sv ----
// Prescaler for the period timer: turns the instruction-clock tick into a count tick.
// Assumes a single clock domain and ticks that last one cycle.
`timescale 1ns/100ps
`default_nettype none
`include "pts_consts.svh"

module pts_scaler (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_clear,
   input wire logic i_tick,
   input wire logic [1:0] i_select,
   output logic o_tick
);
   typedef struct packed {
      logic [3:0] cnt;
   } pts_pre_s;

   pts_pre_s st;
   pts_pre_s next_st;
   logic [3:0] last;

   // Ratio 1:1, 1:4 or 1:16 from the select code
   always_comb begin
      next_st = st;
      unique case (i_select)
         `PTS_PRE_DIV1: last = 4'h0;
         `PTS_PRE_DIV4: last = `PTS_PRE_LAST4;
         default: last = `PTS_PRE_LAST16;
      endcase
      o_tick = i_tick && (st.cnt >= last);
      if (i_clear) begin
         next_st.cnt = 4'h0;
      end else if (i_tick) begin
         next_st.cnt = (st.cnt >= last) ? 4'h0 : st.cnt + `PTS_ONE4;
      end
   end

   // State register
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st <= '0;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   // Count never passes the ratio now selected
   a_pre_bound: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      st.cnt <= last) else $error("prescale count out of range");
endmodule : pts_scaler

`default_nettype wire

// ---- pts_timer.sv ----
// Period timer with prescaler, period match and postscaler, behind a plain register port.
// Assumes a single clock, synchronous software strobes, and any device reset on i_sys_rst.
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "pts_consts.svh"

package pts_pkg;
   typedef struct packed {
      logic [1:0] quarter;
      logic [7:0] count;
      logic [7:0] period;
      logic [6:0] control;
      logic [3:0] post;
      logic flag;
      logic enable;
      logic [7:0] rdata;
      logic match;
   } pts_state_s;
endpackage : pts_pkg

// Overview of operation
// - Eight-bit up-counter fed by a prescaler; postscaler follows its match output.
// - Count register is read/write by software and cleared by every reset.
// - Input is the clock divided by four, prescaled 1:1, 1:4 or 1:16.
// - Count rises from zero to the period, then wraps to zero as a match.
// - Period register is read/write by software and resets to all ones.
// - Four-bit postscaler counts matches and sets the match flag at terminal count.
// - Timer-on bit low stops the counter; high lets it run.
// - Count write, control write or reset clears prescaler and postscaler.
// - Control write leaves the counter value untouched.
// - Match pulse before the postscaler is an output for the serial port.
// - Enable register bit one lets the match flag raise the interrupt.
module pts_timer (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic [`PTS_ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   output logic o_match,
   output logic o_irq
);
   pts_pkg::pts_state_s st;
   pts_pkg::pts_state_s next_st;
   logic wr_count;
   logic wr_control;
   logic wr_period;
   logic wr_flags;
   logic wr_enable;
   logic scaler_clear;
   logic quarter_tick;
   logic count_tick;
   logic step;
   logic hit;
   logic post_done;

   // Register decode
   assign wr_count = i_wr && (i_addr == `PTS_OFF_COUNT);
   assign wr_control = i_wr && (i_addr == `PTS_OFF_CONTROL);
   assign wr_period = i_wr && (i_addr == `PTS_OFF_PERIOD);
   assign wr_flags = i_wr && (i_addr == `PTS_OFF_FLAGS);
   assign wr_enable = i_wr && (i_addr == `PTS_OFF_ENABLE);
   assign scaler_clear = wr_count || wr_control;

   // Clock divided by four, gated by the timer-on bit
   assign quarter_tick = st.control[`PTS_BIT_ON] && (st.quarter == `PTS_QUARTER_LAST);

   pts_scaler u_pre (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_clear(scaler_clear),
      .i_tick(quarter_tick),
      .i_select(st.control[`PTS_CKPS_HI:`PTS_CKPS_LO]),
      .o_tick(count_tick)
   );

   // Count step, held off by a count or control write
   assign step = count_tick && !scaler_clear;
   // Match and postscaler terminal
   assign hit = step && (st.count == st.period);
   assign post_done = hit && (st.post == st.control[`PTS_POST_HI:`PTS_POST_LO]);

   // Next-state logic
   always_comb begin
      next_st = st;
      next_st.match = hit;
      if (st.control[`PTS_BIT_ON]) begin
         next_st.quarter = st.quarter + `PTS_ONE2;
      end
      // Counter
      if (wr_count) begin
         next_st.count = i_wdata;
      end else if (hit) begin
         next_st.count = `PTS_RST_COUNT;
      end else if (step) begin
         next_st.count = st.count + `PTS_ONE8;
      end
      // Postscaler
      if (scaler_clear) begin
         next_st.post = 4'h0;
      end else if (post_done) begin
         next_st.post = 4'h0;
      end else if (hit) begin
         next_st.post = st.post + `PTS_ONE4;
      end
      // Control writes leave count alone
      if (wr_control) begin
         next_st.control = i_wdata[`PTS_CONTROL_W-1:0];
      end
      if (wr_period) begin
         next_st.period = i_wdata;
      end
      if (wr_enable) begin
         next_st.enable = i_wdata[`PTS_BIT_MATCH];
      end
      // Flag: write one clears, a new event wins
      if (wr_flags && i_wdata[`PTS_BIT_MATCH]) begin
         next_st.flag = 1'b0;
      end
      if (post_done) begin
         next_st.flag = 1'b1;
      end
      // Read data, valid the cycle after the strobe
      next_st.rdata = `PTS_RST_ZERO8;
      if (i_rd) begin
         unique case (i_addr)
            `PTS_OFF_COUNT: next_st.rdata = st.count;
            `PTS_OFF_CONTROL: next_st.rdata = {1'b0, st.control};
            `PTS_OFF_PERIOD: next_st.rdata = st.period;
            `PTS_OFF_FLAGS: next_st.rdata = {6'h00, st.flag, 1'b0};
            `PTS_OFF_ENABLE: next_st.rdata = {6'h00, st.enable, 1'b0};
            default: next_st.rdata = `PTS_RST_ZERO8;
         endcase
      end
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st.quarter <= 2'b00;
         st.count <= `PTS_RST_COUNT;
         st.period <= `PTS_RST_PERIOD;
         st.control <= `PTS_RST_CONTROL;
         st.post <= 4'h0;
         st.flag <= 1'b0;
         st.enable <= 1'b0;
         st.rdata <= `PTS_RST_ZERO8;
         st.match <= 1'b0;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   // Outputs
   assign o_rdata = st.rdata;
   assign o_match = st.match;
   assign o_irq = st.flag && st.enable;

   // Assertions
   a_wrap_zero: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_ce && hit) |=> (st.count == `PTS_RST_COUNT) && st.match) else $error("no wrap on match");
   a_stop_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_ce && !st.control[`PTS_BIT_ON] && !wr_count) |=> $stable(st.count)) else $error("count moved while off");
   a_ctl_keep: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_ce && wr_control) |=> (st.count == $past(st.count)) && (st.post == 4'h0)) else $error("control write hit count");
   a_cnt_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_ce && wr_count) |=> (st.count == $past(i_wdata)) && (st.post == 4'h0)) else $error("count write lost");
   a_per_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_ce && wr_period) |=> st.period == $past(i_wdata)) else $error("period write lost");
   a_flag_set: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_ce && post_done) |=> st.flag) else $error("flag not set at terminal");
   a_irq_gate: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_ce && wr_enable && !i_wdata[`PTS_BIT_MATCH]) |=> !o_irq) else $error("irq not gated by enable");
   a_step_one: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_ce && count_tick && !hit && !scaler_clear) |=> st.count == $past(st.count) + `PTS_ONE8) else $error("bad step");
   a_quarter: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_ce && st.control[`PTS_BIT_ON]) |=> (st.quarter == $past(st.quarter) + `PTS_ONE2))
      else $error("divide by four stalled");
   a_match_out: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_ce && hit) |=> o_match) else $error("match not exported");
endmodule : pts_timer

`default_nettype wire

// ---- pts_timer_test.sv ----
// Self-checking bench for the period timer: register port, scalers, match pulse, interrupt.
// Assumes pts_timer and pts_consts.svh; the bench drives every port itself.
`timescale 1ns/100ps
`default_nettype none
`include "pts_consts.svh"

module pts_timer_test;
   logic i_ref_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_ce = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] o_rdata;
   logic o_match;
   logic o_irq;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [7:0] rd_val;
   int gap;
   int n;

   pts_timer pts_timer_inst (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_match(o_match), .o_irq(o_irq));

   // 200 MHz clock
   always #2.5 i_ref_clk = ~i_ref_clk;

   // Cut a hang short
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check_byte

   task automatic check_count(input int got, input int exp, input string what);
      total_checks++;
      if (got != exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %0d expected %0d", $time, what, got, exp);
      end
   endtask : check_count

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask : wr

   // One-cycle read strobe; data sampled in the following cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      @(negedge i_ref_clk);
      d = o_rdata;
   endtask : rd

   // Cycles until the next match pulse
   task automatic next_match(output int cyc);
      cyc = 0;
      do begin
         @(negedge i_ref_clk);
         cyc++;
      end while (o_match !== 1'b1 && cyc < 2000);
   endtask : next_match

   task automatic reset_values();
      rd(`PTS_OFF_COUNT, rd_val); check_byte(rd_val, 8'h00, "count");
      rd(`PTS_OFF_PERIOD, rd_val); check_byte(rd_val, 8'hFF, "period");
      rd(`PTS_OFF_CONTROL, rd_val); check_byte(rd_val, 8'h00, "control");
      rd(`PTS_OFF_FLAGS, rd_val); check_byte(rd_val, 8'h00, "flags");
      rd(`PTS_OFF_ENABLE, rd_val); check_byte(rd_val, 8'h00, "enable");
      rd(8'h20, rd_val); check_byte(rd_val, 8'h00, "unmapped");
   endtask : reset_values

   // Every prescale code with period 3 and postscale 1:1
   task automatic prescale_codes();
      int div;
      wr(`PTS_OFF_PERIOD, 8'h03);
      rd(`PTS_OFF_PERIOD, rd_val); check_byte(rd_val, 8'h03, "period rw");
      for (int c = 0; c < 4; c++) begin
         div = (c == 0) ? 1 : (c == 1) ? 4 : 16;
         wr(`PTS_OFF_CONTROL, 8'h04 | 8'(c));
         next_match(gap);
         next_match(gap);
         check_count(gap, 4 * div * 4, "match interval");
         @(negedge i_ref_clk);
         check_byte({7'h00, o_match}, 8'h00, "match width");
      end
   endtask : prescale_codes

   // Postscale 1:3 sets the flag on the third match; mask and clear
   task automatic postscale_irq();
      wr(`PTS_OFF_CONTROL, 8'h14);
      wr(`PTS_OFF_FLAGS, 8'h02);
      wr(`PTS_OFF_ENABLE, 8'h02);
      wr(`PTS_OFF_COUNT, 8'h00);
      n = 0;
      gap = 0;
      while (o_irq !== 1'b1 && gap < 2000) begin
         @(negedge i_ref_clk);
         gap++;
         n += int'(o_match);
      end
      repeat (2) begin
         @(negedge i_ref_clk);
         n += int'(o_match);
      end
      check_count(n, 3, "matches per flag");
      wr(`PTS_OFF_ENABLE, 8'h00);
      @(negedge i_ref_clk);
      check_byte({7'h00, o_irq}, 8'h00, "masked irq");
      rd(`PTS_OFF_FLAGS, rd_val); check_byte(rd_val, 8'h02, "flag held");
      wr(`PTS_OFF_FLAGS, 8'h02);
      rd(`PTS_OFF_FLAGS, rd_val); check_byte(rd_val, 8'h00, "flag cleared");
   endtask : postscale_irq

   // Timer off holds count; control write keeps count; on resumes
   task automatic stop_and_keep();
      wr(`PTS_OFF_CONTROL, 8'h00);
      wr(`PTS_OFF_PERIOD, 8'hFF);
      wr(`PTS_OFF_COUNT, 8'h42);
      wr(`PTS_OFF_CONTROL, 8'hF8);
      rd(`PTS_OFF_CONTROL, rd_val); check_byte(rd_val, 8'h78, "control bit7");
      repeat (40) @(negedge i_ref_clk);
      rd(`PTS_OFF_COUNT, rd_val); check_byte(rd_val, 8'h42, "count kept");
      wr(`PTS_OFF_CONTROL, 8'h04);
      repeat (40) @(negedge i_ref_clk);
      rd(`PTS_OFF_COUNT, rd_val); check_byte({7'h00, rd_val > 8'h42}, 8'h01, "count runs");
   endtask : stop_and_keep

   // Clock enable low freezes the running timer
   task automatic freeze_hold();
      wr(`PTS_OFF_PERIOD, 8'h03);
      wr(`PTS_OFF_CONTROL, 8'h04);
      wr(`PTS_OFF_COUNT, 8'h00);
      i_ce <= 1'b0;
      n = 0;
      repeat (100) begin
         @(negedge i_ref_clk);
         n += int'(o_match);
      end
      check_count(n, 0, "matches while frozen");
      @(posedge i_ref_clk);
      i_ce <= 1'b1;
      next_match(gap);
      next_match(gap);
      check_count(gap, 16, "interval after freeze");
   endtask : freeze_hold

   // Reset in mid-run restores every register
   task automatic reset_again();
      wr(`PTS_OFF_PERIOD, 8'h55);
      wr(`PTS_OFF_COUNT, 8'h42);
      wr(`PTS_OFF_ENABLE, 8'h02);
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      check_byte({6'h00, o_irq, o_match}, 8'h00, "outputs after reset");
      reset_values();
   endtask : reset_again

   // Main sequence
   initial begin
      repeat (6) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      reset_values();
      prescale_codes();
      postscale_irq();
      stop_and_keep();
      freeze_hold();
      reset_again();
      finish_test();
   end
endmodule : pts_timer_test
`default_nettype wire
